// >>> fhp_host_port.sv
`default_nettype none
module fhp_host_port
	import fhp_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  reset,
	input  wire logic                  clk_en,
	input  wire logic [FHP_DATA_W-1:0] host_data_in,
	output logic      [FHP_DATA_W-1:0] host_data_out,
	output logic                       host_data_oe,
	input  wire logic                  host_read_strobe_n,
	input  wire logic                  host_write_strobe_n,
	input  wire logic [FHP_ADDR_W-1:0] reg_select_addr,
	input  wire logic                  chip_sel_n,
	input  wire logic                  chip_sel_enable,
	output logic                       dma_request,
	input  wire logic                  dma_grant_n,
	input  wire logic                  dma_final_count,
	input  wire logic                  dma_enable,
	input  wire logic                  non_burst_mode,
	input  wire logic                  xfer_dir,
	output logic                       irq_out,
	input  wire logic                  irq_enable,
	input  wire logic                  irq_active_low,
	input  wire logic                  disk_wr_valid,
	input  wire logic [FHP_DATA_W-1:0] disk_wr_data,
	input  wire logic                  disk_rd_req,
	output logic      [FHP_DATA_W-1:0] disk_rd_data,
	output logic                       disk_rd_valid,
	output logic                       fifo_full,
	output logic                       fifo_empty,
	output logic                       overrun_err,
	output logic                       underrun_err,
	output logic                       xfer_done
);
	logic                  rd_n_q;
	logic                  wr_n_q;
	logic [FHP_ADDR_W-1:0] addr_q;
	logic                  acc_dma_q;
	logic                  rd_active_q;
	logic                  rd_load_q;
	logic [FHP_PTR_W-1:0]  wptr_q;
	logic [FHP_PTR_W-1:0]  rptr_q;
	logic [FHP_CNT_W-1:0]  cnt_q;
	logic                  ovr_q;
	logic                  und_q;
	logic                  done_q;
	logic                  drq_q;
	logic                  last_q;
	logic                  gap_q;
	logic                  disk_rd_pend_q;
	logic [FHP_DATA_W-1:0] status_q;
	logic [FHP_DATA_W-1:0] mem_rd_data;

	// Strobe edges and access qualification.
	wire grant = !dma_grant_n;
	wire sel_ok = grant || !chip_sel_enable || !chip_sel_n;
	wire rd_fall = rd_n_q && !host_read_strobe_n;
	wire wr_fall = wr_n_q && !host_write_strobe_n;
	wire rd_start = rd_fall && sel_ok;
	wire wr_start = wr_fall && sel_ok;
	wire rd_end = !rd_n_q && host_read_strobe_n && rd_active_q;
	wire wr_end = !wr_n_q && host_write_strobe_n && sel_ok;
	wire lead_addr = (rd_fall || wr_fall) && sel_ok;
	wire [FHP_ADDR_W-1:0] eff_addr = lead_addr ? reg_select_addr : addr_q;
	wire data_sel = grant || (eff_addr == FHP_ADDR_DATA);

	// FIFO sides; the host side direction follows xfer_dir.
	wire to_host = (xfer_dir == FHP_DIR_TO_HOST);
	wire fifo_full_w = (cnt_q == FHP_CNT_W'(FHP_FIFO_DEPTH));
	wire fifo_empty_w = (cnt_q == '0);
	wire host_push = wr_start && data_sel && !to_host;
	wire host_pop = rd_start && data_sel && to_host;
	wire disk_push = disk_wr_valid && to_host;
	wire disk_pop = disk_rd_req && !to_host;
	wire push_ok = (host_push || disk_push) && !fifo_full_w;
	wire pop_ok = (host_pop || disk_pop) && !fifo_empty_w;
	wire ovr_ev = (host_push || disk_push) && fifo_full_w;
	wire und_ev = (host_pop || disk_pop) && fifo_empty_w;
	wire [FHP_DATA_W-1:0] push_data = disk_push ? disk_wr_data :
		host_data_in;

	// DMA request wanted when a byte can move on the host side.
	wire want = dma_enable && !done_q && !gap_q &&
		(to_host ? !fifo_empty_w : !fifo_full_w);
	wire grant_fall = grant && !acc_dma_q && (rd_start || wr_start);
	// The final count seen with the grant edge already marks the last byte.
	wire drop_now = (last_q || tc_ok) &&
		(grant_fall || (grant && rd_start));
	wire tc_ok = dma_final_count && grant;

	fhp_fifo_mem u_mem (
		.ref_clk (ref_clk),
		.clk_en  (clk_en),
		.wr_en   (push_ok),
		.wr_addr (wptr_q),
		.wr_data (push_data),
		.rd_addr (rptr_q),
		.rd_data (mem_rd_data)
	);

	// Strobe history and latched address.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			addr_q <= '0;
			acc_dma_q <= 1'b0;
			rd_active_q <= 1'b0;
			rd_load_q <= 1'b0;
		end else if (clk_en) begin
			rd_n_q <= host_read_strobe_n;
			wr_n_q <= host_write_strobe_n;
			if (lead_addr) begin
				addr_q <= reg_select_addr;
			end
			acc_dma_q <= grant;
			rd_load_q <= rd_start;
			if (rd_start) begin
				rd_active_q <= 1'b1;
			end else if (rd_end) begin
				rd_active_q <= 1'b0;
			end
		end
	end

	// FIFO pointers, fill count and error flags.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wptr_q <= '0;
			rptr_q <= '0;
			cnt_q <= '0;
			ovr_q <= 1'b0;
			und_q <= 1'b0;
		end else if (clk_en) begin
			if (push_ok) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (pop_ok) begin
				rptr_q <= rptr_q + 1'b1;
			end
			cnt_q <= cnt_q + FHP_CNT_W'(push_ok) - FHP_CNT_W'(pop_ok);
			ovr_q <= ovr_q || ovr_ev;
			und_q <= und_q || und_ev;
		end
	end

	// DMA request, final byte and non-burst gap.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			drq_q <= 1'b0;
			last_q <= 1'b0;
			gap_q <= 1'b0;
			done_q <= 1'b0;
		end else if (clk_en) begin
			if (tc_ok) begin
				last_q <= 1'b1;
			end else if (!grant) begin
				last_q <= 1'b0;
			end
			if (drop_now || (tc_ok && (rd_end || wr_end))) begin
				done_q <= 1'b1;
			end else if (!dma_enable) begin
				done_q <= 1'b0;
			end
			// Non-burst releases the request after each byte.
			gap_q <= non_burst_mode && grant && (rd_end || wr_end);
			drq_q <= want && !drop_now && !(tc_ok && (rd_end || wr_end));
		end
	end

	// Read data register and bus drive.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			host_data_out <= FHP_BYTE_ZERO;
			host_data_oe <= 1'b0;
			status_q <= FHP_BYTE_ZERO;
			disk_rd_pend_q <= 1'b0;
			disk_rd_valid <= 1'b0;
			disk_rd_data <= FHP_BYTE_ZERO;
		end else if (clk_en) begin
			status_q <= '0;
			status_q[FHP_ST_EMPTY] <= fifo_empty_w;
			status_q[FHP_ST_FULL] <= fifo_full_w;
			status_q[FHP_ST_OVR] <= ovr_q;
			status_q[FHP_ST_UND] <= und_q;
			status_q[FHP_ST_DONE] <= done_q;
			status_q[FHP_ST_DRQ] <= drq_q;
			if (rd_start) begin
				host_data_oe <= 1'b1;
			end else if (host_read_strobe_n) begin
				host_data_oe <= 1'b0;
			end
			if (rd_load_q) begin // Once per read, so a later pop keeps it.
				host_data_out <= data_sel ? mem_rd_data : status_q;
			end
			disk_rd_pend_q <= disk_pop && !fifo_empty_w;
			disk_rd_valid <= disk_rd_pend_q;
			if (disk_rd_pend_q) begin
				disk_rd_data <= mem_rd_data;
			end
		end
	end

	// Interrupt output polarity and status outputs.
	wire irq_raw = irq_enable && (done_q || ovr_q || und_q);
	assign irq_out = irq_raw ^ irq_active_low;
	assign dma_request = drq_q;
	assign fifo_full = fifo_full_w;
	assign fifo_empty = fifo_empty_w;
	assign overrun_err = ovr_q;
	assign underrun_err = und_q;
	assign xfer_done = done_q;

	// Checks that sit beside the logic.
	AST_BUS_IDLE: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && host_read_strobe_n |=> !host_data_oe)
		else $error("Data bus driven without read strobe.");
	AST_ADDR_LATCH: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && lead_addr |=> addr_q == $past(reg_select_addr))
		else $error("Select address not latched at strobe edge.");
	AST_DRQ_DROP: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && drop_now |=> !dma_request)
		else $error("Request not dropped on last byte.");
	AST_TC_GATE: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && dma_grant_n && !done_q ##1 clk_en && dma_grant_n
		|-> !done_q)
		else $error("Final count taken without grant.");
	AST_CS_IGNORE: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && chip_sel_enable && chip_sel_n && dma_grant_n && rd_fall
		|=> !host_data_oe)
		else $error("Unselected read drove the bus.");
	AST_OVR: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && ovr_ev |=> overrun_err)
		else $error("Overrun not reported.");
	AST_UND: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && und_ev |=> underrun_err)
		else $error("Underrun not reported.");
	AST_NO_OVERFILL: assert property (@(posedge ref_clk) disable iff (reset)
		cnt_q <= FHP_CNT_W'(FHP_FIFO_DEPTH))
		else $error("Fill count beyond depth.");
	AST_NONBURST: assert property (@(posedge ref_clk) disable iff (reset)
		clk_en && non_burst_mode && grant && (rd_end || wr_end)
		##1 clk_en |=> !dma_request)
		else $error("Non-burst request not released.");
	COV_FULL: cover property (@(posedge ref_clk) fifo_full_w);
	COV_DROP: cover property (@(posedge ref_clk) drop_now);
	COV_OVR: cover property (@(posedge ref_clk) ovr_ev);
	COV_GAP: cover property (@(posedge ref_clk) gap_q);
endmodule // fhp_host_port
`default_nettype wire

// >>> fhp_pkg.sv
`default_nettype none
package fhp_pkg;
	localparam int FHP_DATA_W = 8;
	localparam int FHP_ADDR_W = 3;
	localparam int FHP_FIFO_DEPTH = 16;
	localparam int FHP_PTR_W = 4;
	localparam int FHP_CNT_W = 5;
	// Register select addresses of the data path and the status byte.
	localparam logic [2:0] FHP_ADDR_STATUS = 3'h4;
	localparam logic [2:0] FHP_ADDR_DATA = 3'h5;
	// Status byte field positions.
	localparam int FHP_ST_EMPTY = 0;
	localparam int FHP_ST_FULL = 1;
	localparam int FHP_ST_OVR = 2;
	localparam int FHP_ST_UND = 3;
	localparam int FHP_ST_DONE = 4;
	localparam int FHP_ST_DRQ = 5;
	// Minimum reset time and its cycle count at 50 MHz.
	localparam int FHP_CLK_MHZ = 50;
	localparam int FHP_RESET_MIN_NS = 500;
	localparam int FHP_RESET_CYC =
		(FHP_RESET_MIN_NS * FHP_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] FHP_BYTE_ZERO = 8'h00;
	typedef enum logic {FHP_DIR_TO_HOST, FHP_DIR_FROM_HOST} fhp_dir_t;
endpackage
`default_nettype wire

// >>> fhp_fifo_mem.sv
`default_nettype none
module fhp_fifo_mem
	import fhp_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  clk_en,
	input  wire logic                  wr_en,
	input  wire logic [FHP_PTR_W-1:0]  wr_addr,
	input  wire logic [FHP_DATA_W-1:0] wr_data,
	input  wire logic [FHP_PTR_W-1:0]  rd_addr,
	output logic      [FHP_DATA_W-1:0] rd_data
);
	logic [FHP_DATA_W-1:0] mem_q [FHP_FIFO_DEPTH];

	// Write port and registered read port.
	always_ff @(posedge ref_clk) begin
		if (clk_en && wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
		if (clk_en) begin
			rd_data <= mem_q[rd_addr];
		end
	end
endmodule // fhp_fifo_mem
`default_nettype wire

// >>> fhp_host_model.sv
`default_nettype none
module fhp_host_model
	import fhp_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic [FHP_DATA_W-1:0] host_data_out,
	input  wire logic                  host_data_oe,
	output logic      [FHP_DATA_W-1:0] host_data_in,
	output logic                       host_read_strobe_n,
	output logic                       host_write_strobe_n,
	output logic      [FHP_ADDR_W-1:0] reg_select_addr,
	output logic                       chip_sel_n,
	output logic                       dma_grant_n,
	output logic                       dma_final_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [FHP_DATA_W-1:0] wd_q;
	logic                  drv_q;
	logic [FHP_DATA_W-1:0] last_q = 8'h5a;
	// Floating bus flips every cycle so stale data is never mistaken.
	assign host_data_in = host_data_oe ? host_data_out : drv_q ? wd_q : ~last_q;
	always @(posedge ref_clk) begin
		last_q <= host_data_in;
	end
	// The host and the DMA controller start idle.
	initial begin
		{host_read_strobe_n, host_write_strobe_n, chip_sel_n} = 3'h7;
		{dma_grant_n, dma_final_count, drv_q} = 3'h4;
		reg_select_addr = 3'h0;
		wd_q = 8'h00;
	end
	// One access; m is write, grant and select. Held four edges low.
	task automatic xfer(input logic [2:0] m, input logic [2:0] a,
		input logic [7:0] wd, input logic tc, output logic [7:0] rd);
		@(posedge ref_clk);
		reg_select_addr <= a;
		chip_sel_n <= ~m[0];
		dma_grant_n <= ~m[1];
		dma_final_count <= tc;
		wd_q <= wd;
		drv_q <= m[2];
		if (m[2]) host_write_strobe_n <= 1'b0;
		else host_read_strobe_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		@(negedge ref_clk);
		rd = host_data_out;
		@(posedge ref_clk);
		host_read_strobe_n <= 1'b1;
		host_write_strobe_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		{dma_grant_n, chip_sel_n, drv_q, dma_final_count} <= 4'hc;
	endtask
endmodule // fhp_host_model
`default_nettype wire

// >>> floppy_ctrl_host_dma_port_bench.sv
`default_nettype none
module floppy_ctrl_host_dma_port_bench
	import fhp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk, reset, dma_enable, non_burst_mode, xfer_dir;
	logic irq_enable, irq_active_low, chip_sel_enable;
	logic disk_wr_valid, disk_rd_req, host_data_oe, irq_out, disk_rd_valid;
	logic [7:0] disk_wr_data, rd, host_data_in, host_data_out, disk_rd_data;
	logic [2:0] reg_select_addr;
	logic host_read_strobe_n, host_write_strobe_n, chip_sel_n, dma_request;
	logic dma_grant_n, dma_final_count, fifo_full, fifo_empty;
	logic overrun_err, underrun_err, xfer_done;
	logic [7:0] flags;
	int fail_count = 0;
	int checks_done = 0;
	// Flags gathered in the status byte layout.
	assign flags = {2'h0, dma_request, xfer_done, underrun_err, overrun_err,
		fifo_full, fifo_empty};
	fhp_host_port i_dut (.ref_clk, .reset, .clk_en(1'b1), .host_data_in,
		.host_data_out, .host_data_oe, .host_read_strobe_n,
		.host_write_strobe_n, .reg_select_addr, .chip_sel_n,
		.chip_sel_enable, .dma_request, .dma_grant_n, .dma_final_count,
		.dma_enable, .non_burst_mode, .xfer_dir, .irq_out, .irq_enable,
		.irq_active_low, .disk_wr_valid, .disk_wr_data, .disk_rd_req,
		.disk_rd_data, .disk_rd_valid, .fifo_full, .fifo_empty,
		.overrun_err, .underrun_err, .xfer_done);
	fhp_host_model i_host (.ref_clk, .host_data_out, .host_data_oe,
		.host_data_in, .host_read_strobe_n, .host_write_strobe_n,
		.reg_select_addr, .chip_sel_n, .dma_grant_n, .dma_final_count);
	// Free running clock.
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	task automatic chk(input string name, input logic [7:0] exp,
		input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Pops one byte on the disk side and waits for it to come back.
	task automatic pop(output logic [7:0] d);
		disk_rd_req <= 1'b1;
		@(posedge ref_clk);
		disk_rd_req <= 1'b0;
		d = 8'hxx;
		repeat (4) begin
			@(negedge ref_clk);
			if (disk_rd_valid === 1'b1) d = disk_rd_data;
			@(posedge ref_clk);
		end
	endtask
	// Host fills the buffer past full, then the disk side drains it dry.
	task automatic t_fifo();
		xfer_dir <= 1'b1;
		i_host.xfer(3'h4, FHP_ADDR_DATA, 8'h77, 1'b0, rd);
		chk("ignored write", 8'h01, flags);
		for (int i = 0; i < FHP_FIFO_DEPTH; i++)
			i_host.xfer(3'h5, FHP_ADDR_DATA, 8'h30 + 8'(i), 1'b0, rd);
		i_host.xfer(3'h5, FHP_ADDR_DATA, 8'hee, 1'b0, rd);
		i_host.xfer(3'h1, FHP_ADDR_STATUS, 8'h00, 1'b0, rd);
		chk("status", 8'h06, rd & 8'h3f);
		for (int i = 0; i < FHP_FIFO_DEPTH; i++) begin
			pop(rd);
			chk("disk byte", 8'h30 + 8'(i), rd);
		end
		pop(rd);
		chk("drained flags", 8'h0d, flags);
	endtask
	// Disk fills three bytes; DMA moves them, the last with final count.
	task automatic t_dma();
		xfer_dir <= 1'b0;
		reset <= 1'b1;
		repeat (FHP_RESET_CYC) @(posedge ref_clk);
		reset <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			disk_wr_valid <= 1'b1;
			disk_wr_data <= 8'ha0 + 8'(i);
			@(posedge ref_clk);
		end
		disk_wr_valid <= 1'b0;
		i_host.xfer(3'h0, FHP_ADDR_DATA, 8'h00, 1'b0, rd);
		chk("unselected read", 8'h00, rd);
		i_host.xfer(3'h1, FHP_ADDR_STATUS, 8'h00, 1'b1, rd);
		chk("count without grant", 8'h00, flags);
		dma_enable <= 1'b1;
		for (int i = 0; i < 4 && dma_request !== 1'b1; i++) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("request", 8'h20, flags & 8'h20);
		for (int i = 0; i < 3; i++) begin
			i_host.xfer(3'h2, FHP_ADDR_DATA, 8'h00, 1'(i == 2), rd);
			chk("dma byte", 8'ha0 + 8'(i), rd);
		end
		chk("final flags", 8'h11, flags);
	endtask
	// Flipping the polarity setting inverts the interrupt output.
	task automatic t_irq();
		irq_enable <= 1'b1;
		@(negedge ref_clk);
		chk("irq level", 8'h01, {7'h0, irq_out});
		@(posedge ref_clk);
		irq_active_low <= 1'b1;
		@(negedge ref_clk);
		chk("irq low level", 8'h00, {7'h0, irq_out});
		@(posedge ref_clk);
		irq_active_low <= 1'b0;
		irq_enable <= 1'b0;
	endtask
	// Non-burst DMA write, then a status read with chip select switched off.
	task automatic t_nonburst();
		dma_enable <= 1'b0;
		xfer_dir <= 1'b1;
		non_burst_mode <= 1'b1;
		@(posedge ref_clk);
		dma_enable <= 1'b1;
		i_host.xfer(3'h6, FHP_ADDR_DATA, 8'h5c, 1'b0, rd);
		@(negedge ref_clk);
		chk("non-burst gap", 8'h00, flags & 8'h20);
		@(posedge ref_clk);
		chip_sel_enable <= 1'b0;
		i_host.xfer(3'h0, FHP_ADDR_STATUS, 8'h00, 1'b0, rd);
		chk("select off read", 8'h20, rd & 8'h3f);
		chip_sel_enable <= 1'b1;
		pop(rd);
		chk("dma write byte", 8'h5c, rd);
	endtask
	// Main sequence.
	initial begin
		{reset, dma_enable, non_burst_mode, xfer_dir, irq_enable} = 5'h10;
		{irq_active_low, chip_sel_enable, disk_wr_valid, disk_rd_req} = 4'h4;
		disk_wr_data = 8'h00;
		repeat (5) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		chk("reset flags", 8'h01, flags);
		chk("bus enable", 8'h00, {7'h0, host_data_oe});
		@(posedge ref_clk);
		t_fifo();
		t_dma();
		t_irq();
		t_nonburst();
		report_and_stop();
	end
	// Cuts a hang short well after the tests should have ended.
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end
endmodule // floppy_ctrl_host_dma_port_bench
`default_nettype wire
